// ### rtl/output_compare_unit.sv
// output compare channel: control, primary and secondary compare registers
// assumes timers, idle flag and register port run on clk_in; fault pin is async
//
// Design decisions made here: strobed register access and the register addresses.
`default_nettype none

module output_compare_unit
  import output_compare_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  output logic [31:0] rdata_out,
  // time bases and processor state
  input wire timer_type first_timer_in,
  input wire timer_type second_timer_in,
  input wire logic idle_mode_in,
  // pins
  input wire logic fault_pin_n_in,
  output logic compare_output_pin_out
);

  ctrl_type ctrl_reg;
  logic fault_reg;
  logic [31:0] primary_reg;
  logic [31:0] secondary_reg;
  logic pin_reg;
  pulse_state_type pulse_reg;
  logic [3:0] prev_reg;
  logic [31:0] rdata_reg;

  logic [1:0] alias_kind;
  logic addr_ok;
  logic sel_ctrl;
  logic sel_primary;
  logic sel_secondary;
  logic fault_visible;
  logic [31:0] ctrl_word;
  logic [31:0] ctrl_next;
  timer_type timebase;
  logic run;
  logic start;
  logic pwm_mode;
  logic pwm_reload;
  logic fault_sync_n;
  logic primary_match;
  logic secondary_match;

  // address decode: word aligned only, bits 3:2 pick the alias
  assign alias_kind = addr_in[3:2];
  assign addr_ok = (addr_in[1:0] == 2'h0);
  assign sel_ctrl = addr_ok && ({addr_in[7:4], 4'h0} == CTRL_OFFSET);
  assign sel_primary = addr_ok && ({addr_in[7:4], 4'h0} == PRIMARY_OFFSET);
  assign sel_secondary = addr_ok && ({addr_in[7:4], 4'h0} == SECONDARY_OFFSET);

  assign fault_visible = fault_reg && (ctrl_reg.mode == MODE_PWM_FAULT);

  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[ENABLE_BIT] = ctrl_reg.enable;
    ctrl_word[IDLE_STOP_BIT] = ctrl_reg.idle_stop;
    ctrl_word[WIDE_BIT] = ctrl_reg.wide;
    ctrl_word[FAULT_BIT] = fault_visible;
    ctrl_word[TIMEBASE_BIT] = ctrl_reg.timebase;
    ctrl_word[MODE_LSB +: 3] = ctrl_reg.mode;
  end

  assign ctrl_next = alias_write(ctrl_word, wdata_in, alias_kind);

  // control register; the fault bit of ctrl_next is simply not taken
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      ctrl_reg <= CTRL_RESET;
    end else if (write_in && sel_ctrl) begin
      ctrl_reg.enable <= ctrl_next[ENABLE_BIT];
      ctrl_reg.idle_stop <= ctrl_next[IDLE_STOP_BIT];
      ctrl_reg.wide <= ctrl_next[WIDE_BIT];
      ctrl_reg.timebase <= ctrl_next[TIMEBASE_BIT];
      ctrl_reg.mode <= ctrl_next[MODE_LSB +: 3];
    end
  end

  assign timebase = ctrl_reg.timebase ? second_timer_in : first_timer_in;

  assign run = ctrl_reg.enable && !(ctrl_reg.idle_stop && idle_mode_in);

  // a new mode or a fresh enable restarts the initial pin level
  assign start = ctrl_reg.enable && ({ctrl_reg.enable, ctrl_reg.mode} != prev_reg);
  assign pwm_mode = (ctrl_reg.mode == MODE_PWM) || (ctrl_reg.mode == MODE_PWM_FAULT);
  assign pwm_reload = run && pwm_mode && timebase.period;

  // held while suspended so a mode written during idle still restarts later
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      prev_reg <= 4'h0;
    end else if (run || !ctrl_reg.enable) begin
      prev_reg <= {ctrl_reg.enable, ctrl_reg.mode};
    end
  end

  always_ff @(posedge clk_in) begin
    if (write_in && sel_primary) begin
      primary_reg <= alias_write(primary_reg, wdata_in, alias_kind);
    end else if (pwm_reload) begin
      primary_reg <= secondary_reg;
    end
  end

  // secondary is the buffered duty in pwm, the falling edge in pulse modes
  always_ff @(posedge clk_in) begin
    if (write_in && sel_secondary) begin
      secondary_reg <= alias_write(secondary_reg, wdata_in, alias_kind);
    end
  end

  // fault pin is asynchronous: two flops before any use
  level_sync #(
    .RESET_VALUE(1'b1)
  ) u_fault_sync (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .level_in(fault_pin_n_in),
    .level_out(fault_sync_n)
  );

  match_detect #(
    .WIDTH(32)
  ) u_primary_match (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .run_in(run),
    .wide_in(ctrl_reg.wide),
    .count_in(timebase.count),
    .value_in(primary_reg),
    .match_out(primary_match)
  );

  // second comparator ends the pulse in the pulse modes
  match_detect #(
    .WIDTH(32)
  ) u_secondary_match (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .run_in(run),
    .wide_in(ctrl_reg.wide),
    .count_in(timebase.count),
    .value_in(secondary_reg),
    .match_out(secondary_match)
  );

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      fault_reg <= 1'b0;
    end else if (run && ctrl_reg.mode == MODE_PWM_FAULT && !fault_sync_n) begin
      fault_reg <= 1'b1;
    end else if (ctrl_reg.mode != MODE_PWM_FAULT) begin
      fault_reg <= 1'b0;
    end
  end

  // output pin and pulse sequencing
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      pin_reg <= 1'b0;
      pulse_reg <= PS_ARMED;
    end else if (!ctrl_reg.enable) begin
      pin_reg <= 1'b0;
      pulse_reg <= PS_ARMED;
    end else if (run) begin
      if (start) begin
        pin_reg <= (ctrl_reg.mode == MODE_CLEAR_ON_MATCH);
        pulse_reg <= PS_ARMED;
      end else begin
        case (ctrl_reg.mode)
          MODE_OFF: begin
            pin_reg <= 1'b0;
          end
          MODE_SET_ON_MATCH: begin
            if (primary_match) pin_reg <= 1'b1;
          end
          MODE_CLEAR_ON_MATCH: begin
            if (primary_match) pin_reg <= 1'b0;
          end
          MODE_TOGGLE: begin
            if (primary_match) pin_reg <= ~pin_reg;
          end
          MODE_SINGLE, MODE_CONTINUOUS: begin
            case (pulse_reg)
              PS_ARMED: begin
                if (primary_match) begin
                  pin_reg <= 1'b1;
                  pulse_reg <= PS_HIGH;
                end
              end
              PS_HIGH: begin
                if (secondary_match) begin
                  pin_reg <= 1'b0;
                  pulse_reg <= (ctrl_reg.mode == MODE_SINGLE) ? PS_DONE : PS_ARMED;
                end
              end
              default: begin
                pin_reg <= 1'b0;
              end
            endcase
          end
          default: begin
            // pwm, fault only honoured in 111
            if (fault_visible) begin
              pin_reg <= 1'b0;
            end else if (timebase.period) begin
              pin_reg <= 1'b1;
            end else if (primary_match) begin
              pin_reg <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  // read data stand one cycle only; aliases and holes read zero
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      rdata_reg <= 32'h0000_0000;
    end else if (read_in && alias_kind == ALIAS_NONE && sel_ctrl) begin
      rdata_reg <= ctrl_word;
    end else if (read_in && alias_kind == ALIAS_NONE && sel_primary) begin
      rdata_reg <= primary_reg;
    end else if (read_in && alias_kind == ALIAS_NONE && sel_secondary) begin
      rdata_reg <= secondary_reg;
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign rdata_out = rdata_reg;
  assign compare_output_pin_out = pin_reg;

  // checks on the channel behaviour
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  a_off_pin_low: assert property (!ctrl_reg.enable |=> !pin_reg)
    else $error("pin not low while channel disabled");

  a_idle_pin_held: assert property (ctrl_reg.enable && ctrl_reg.idle_stop && idle_mode_in
      |=> $stable(pin_reg))
    else $error("pin moved while suspended in idle");

  a_fault_stays_set: assert property (fault_reg && ctrl_reg.mode == MODE_PWM_FAULT
      |=> fault_reg)
    else $error("fault status lost while in mode 111");

  a_fault_reads_zero: assert property (read_in && sel_ctrl && alias_kind == ALIAS_NONE
      && ctrl_reg.mode != MODE_PWM_FAULT |=> !rdata_out[FAULT_BIT])
    else $error("fault bit read as one outside mode 111");

  a_fault_caught: assert property (run && ctrl_reg.mode == MODE_PWM_FAULT && !fault_sync_n
      |=> fault_reg)
    else $error("fault not captured in mode 111");

  // a mode change or idle suspend after the capture must not trip the pin check
  a_fault_pin_low: assert property (fault_visible && run |=> !pin_reg)
    else $error("pin not forced low during a pwm fault");

  a_toggle_match: assert property (run && !start && ctrl_reg.mode == MODE_TOGGLE
      && primary_match |=> pin_reg != $past(pin_reg))
    else $error("toggle mode did not invert pin on match");

  a_set_on_match: assert property (run && !start && ctrl_reg.mode == MODE_SET_ON_MATCH
      && primary_match |=> pin_reg)
    else $error("pin not high after match in mode 001");

  a_single_pulse_end: assert property (run && !start && ctrl_reg.mode == MODE_SINGLE
      && pulse_reg == PS_HIGH && secondary_match |=> pulse_reg == PS_DONE && !pin_reg)
    else $error("single pulse did not end and stop");

  a_unused_bits_zero: assert property (read_in && sel_ctrl && alias_kind == ALIAS_NONE
      |=> rdata_out[31:16] == 16'h0000 && rdata_out[14] == 1'b0
      && rdata_out[12:6] == 7'h00)
    else $error("unimplemented control bits read nonzero");

  a_duty_reload: assert property (pwm_reload && !(write_in && sel_primary)
      |=> primary_reg == $past(secondary_reg))
    else $error("duty not reloaded at period boundary");

  c_single_done: cover property (pulse_reg == PS_HIGH ##1 pulse_reg == PS_DONE);
  c_toggle_match: cover property (ctrl_reg.mode == MODE_TOGGLE && primary_match);
  c_fault_set: cover property (!fault_reg ##1 fault_reg);
  c_pwm_reload: cover property (pwm_reload);

endmodule : output_compare_unit

`default_nettype wire

// ### rtl/output_compare_pkg.sv
// shared constants, types and helpers of the output compare channel
// assumes a 32-bit register port with byte addresses and one 100 MHz clock
`default_nettype none

package output_compare_pkg;

  // register byte offsets (each with clear/set/invert aliases above)
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] PRIMARY_OFFSET = 8'h10;
  localparam logic [7:0] SECONDARY_OFFSET = 8'h20;

  // alias selector taken from address bits 3:2 (offsets 0x0, 0x4, 0x8, 0xC)
  localparam logic [1:0] ALIAS_NONE = 2'h0;
  localparam logic [1:0] ALIAS_CLR = 2'h1;
  localparam logic [1:0] ALIAS_SET = 2'h2;
  localparam logic [1:0] ALIAS_INV = 2'h3;

  // control field positions
  localparam int ENABLE_BIT = 15;
  localparam int IDLE_STOP_BIT = 13;
  localparam int WIDE_BIT = 5;
  localparam int FAULT_BIT = 4;
  localparam int TIMEBASE_BIT = 3;
  localparam int MODE_LSB = 0;

  // compare_mode_field codes
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_SET_ON_MATCH = 3'h1;
  localparam logic [2:0] MODE_CLEAR_ON_MATCH = 3'h2;
  localparam logic [2:0] MODE_TOGGLE = 3'h3;
  localparam logic [2:0] MODE_SINGLE = 3'h4;
  localparam logic [2:0] MODE_CONTINUOUS = 3'h5;
  localparam logic [2:0] MODE_PWM = 3'h6;
  localparam logic [2:0] MODE_PWM_FAULT = 3'h7;

  // compare_channel_control fields
  typedef struct packed {
    logic enable;
    logic idle_stop;
    logic wide;
    logic timebase;
    logic [2:0] mode;
  } ctrl_type;

  localparam ctrl_type CTRL_RESET = '{1'b0, 1'b0, 1'b0, 1'b0, MODE_OFF};

  // one general timer as seen by the channel
  typedef struct packed {
    logic [31:0] count;
    logic period;
  } timer_type;

  // pulse modes walk armed -> high -> armed/done
  typedef enum logic [1:0] {PS_ARMED, PS_HIGH, PS_DONE} pulse_state_type;

  // applies a plain, clear, set or invert write to an old value
  function automatic logic [31:0] alias_write(input logic [31:0] old_value,
      input logic [31:0] data, input logic [1:0] kind);
    logic [31:0] result;
    result = data;
    case (kind)
      ALIAS_CLR: result = old_value & ~data;
      ALIAS_SET: result = old_value | data;
      ALIAS_INV: result = old_value ^ data;
      default: result = data;
    endcase
    return result;
  endfunction : alias_write

endpackage : output_compare_pkg

`default_nettype wire

// ### rtl/level_sync.sv
// two flip-flop synchroniser for one level from a pin
// assumes the level may change at any time relative to clk_in
`default_nettype none

module level_sync #(
  parameter logic RESET_VALUE = 1'b0
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // level
  input wire logic level_in,
  output logic level_out
);

  logic meta_reg;
  logic stable_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      meta_reg <= RESET_VALUE;
      stable_reg <= RESET_VALUE;
    end else begin
      meta_reg <= level_in;
      stable_reg <= meta_reg;
    end
  end

  assign level_out = stable_reg;

endmodule : level_sync

`default_nettype wire

// ### rtl/match_detect.sv
// compare event detector: count against a value at full or half width
// assumes count and value come from logic on the same clock
`default_nettype none

module match_detect #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // control
  input wire logic run_in,
  input wire logic wide_in,
  // operands
  input wire logic [WIDTH-1:0] count_in,
  input wire logic [WIDTH-1:0] value_in,
  // event
  output logic match_out
);

  localparam int HALF = WIDTH / 2;

  if (WIDTH < 2 || (WIDTH % 2) != 0) begin : g_width_check
    $error("match_detect: WIDTH must be even and at least 2");
  end

  logic equal;
  logic equal_prev_reg;

  // narrow mode looks only at the low half of both operands
  assign equal = wide_in ? (count_in == value_in)
                         : (count_in[HALF-1:0] == value_in[HALF-1:0]);

  // reset high so an equal value at start-up is not taken as an event
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      equal_prev_reg <= 1'b1;
    end else begin
      equal_prev_reg <= equal;
    end
  end

  // one pulse when equality begins; a stalled timer gives no repeats
  assign match_out = run_in && equal && !equal_prev_reg;

endmodule : match_detect

`default_nettype wire

// ### verification/load_model.sv
// external load on the compare pin: counts rising edges, drives the fault line
// assumes pin and fault request change just after rising edges of clk_in
`default_nettype none

module load_model (
  // clock
  input wire logic clk_in,
  // pin side
  input wire logic pin_in,
  input wire logic fault_req_in,
  output logic fault_pin_n_out,
  output logic [15:0] rise_count_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic last_pin_reg = 1'b0;
  logic [15:0] count_reg = 16'h0000;

  // line idles high like a pulled-up open-drain fault line
  assign fault_pin_n_out = !fault_req_in;

  // count rising edges so extra or missing pulses show up; one driver only
  always @(posedge clk_in) begin
    if (pin_in === 1'b1 && last_pin_reg !== 1'b1) begin
      count_reg <= count_reg + 16'h0001;
    end
    last_pin_reg <= pin_in;
  end
  assign rise_count_out = count_reg;
endmodule : load_model

`default_nettype wire

// ### verification/testbench.sv
// self-checking bench of the output compare channel
// assumes the package, the channel and the load model are compiled first
`default_nettype none

module testbench
  import output_compare_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [31:0] prim;
    logic idle;
    logic [4:0] exp;
  } case_type;

  localparam logic [15:0] LAST = 16'h0027;
  // pin expected at counts 7, 15, 25, then 5, 15 of the next timer cycle
  localparam case_type CASES [15] = '{
    '{16'h8000, 32'h0000_000A, 1'b0, 5'b00000},
    '{16'h8001, 32'h0000_000A, 1'b0, 5'b01111},
    '{16'h8002, 32'h0000_000A, 1'b0, 5'b10000},
    '{16'h8003, 32'h0000_000A, 1'b0, 5'b01110},
    '{16'h8004, 32'h0000_000A, 1'b0, 5'b01000},
    '{16'h8005, 32'h0000_000A, 1'b0, 5'b01001},
    '{16'h8006, 32'h0000_000A, 1'b0, 5'b00011},
    '{16'h8007, 32'h0000_000A, 1'b0, 5'b00011},
    '{16'h0001, 32'h0000_000A, 1'b0, 5'b00000},
    '{16'h8009, 32'h0000_000A, 1'b0, 5'b01111},
    '{16'h8021, 32'h0001_000A, 1'b0, 5'b00000},
    '{16'h8021, 32'h0000_000A, 1'b0, 5'b01111},
    '{16'h8001, 32'h0001_000A, 1'b0, 5'b01111},
    '{16'hA001, 32'h0000_000A, 1'b1, 5'b00000},
    '{16'h8001, 32'h0000_000A, 1'b1, 5'b01111}
  };

  logic clk_in, reset_n_in, write_in, read_in, idle_mode_in, fault_req;
  logic [7:0] addr_in;
  logic [31:0] wdata_in, rdata_out, seed;
  logic compare_output_pin_out, fault_pin_n_in;
  logic rd_seen = 1'b0;
  logic [15:0] rises;
  logic [15:0] cnt [2] = '{16'h0000, 16'h0000};
  logic [1:0] run;
  timer_type first_timer_in, second_timer_in;
  logic [31:0] exp_q [$];
  int n_fail = 0;
  int num_checks = 0;
  int cycles = 0;

  output_compare_unit DUT (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .write_in(write_in),
    .read_in(read_in),
    .rdata_out(rdata_out),
    .first_timer_in(first_timer_in),
    .second_timer_in(second_timer_in),
    .idle_mode_in(idle_mode_in),
    .fault_pin_n_in(fault_pin_n_in),
    .compare_output_pin_out(compare_output_pin_out)
  );

  load_model far_end (
    .clk_in(clk_in),
    .pin_in(compare_output_pin_out),
    .fault_req_in(fault_req),
    .fault_pin_n_out(fault_pin_n_in),
    .rise_count_out(rises)
  );

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // time bases; a stopped one sits at zero with no period pulse
  always @(posedge clk_in) begin
    for (int i = 0; i < 2; i++) begin
      cnt[i] <= (!run[i] || cnt[i] == LAST) ? 16'h0000 : cnt[i] + 16'h0001;
    end
  end
  assign first_timer_in = '{{16'h0000, cnt[0]}, run[0] && cnt[0] == 16'h0000};
  assign second_timer_in = '{{16'h0000, cnt[1]}, run[1] && cnt[1] == 16'h0000};

  task automatic compare(input string name, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask : compare

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  // read data stands only in the cycle after the strobe; hang guard too
  always @(posedge clk_in) begin
    rd_seen <= read_in;
    if (rd_seen === 1'b1) begin
      compare("rdata", exp_q.pop_front(), rdata_out);
    end
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_fail++;
      $display("BAD timeout expected done seen hang");
      wrap_up();
    end
  end

  // strobe then an idle cycle, so no access follows a disable at once
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_in <= a;
    wdata_in <= d;
    write_in <= 1'b1;
    @(posedge clk_in);
    write_in <= 1'b0;
    @(posedge clk_in);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    addr_in <= a;
    read_in <= 1'b1;
    @(posedge clk_in);
    read_in <= 1'b0;
    @(posedge clk_in);
  endtask : rd

  task automatic wait_cnt(input logic sel, input logic [15:0] v);
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (cnt[sel] !== v && n < 100);
  endtask : wait_cnt

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // rising edges implied by an expected pin sequence that starts from low
  function automatic logic [31:0] rise_of(input logic [4:0] e);
    logic [31:0] r;
    r = {31'h0, e[4]};
    for (int k = 3; k >= 0; k--) begin
      r += {31'h0, e[k] & ~e[k + 1]};
    end
    return r;
  endfunction : rise_of

  // only the selected time base runs, so a wrong selection never matches
  task automatic run_case(input case_type c);
    logic sel;
    logic [15:0] r0;
    logic [15:0] pts [5];
    sel = c.ctrl[TIMEBASE_BIT];
    pts = '{16'h0007, 16'h000F, 16'h0019, 16'h0005, 16'h000F};
    run[sel] <= 1'b1;
    run[!sel] <= 1'b0;
    wr(CTRL_OFFSET, 32'h0000_0000);
    wr(PRIMARY_OFFSET, c.prim);
    wr(SECONDARY_OFFSET, c.prim + 32'h0000_000A);
    idle_mode_in <= c.idle;
    r0 = rises;
    wait_cnt(sel, 16'h0002);
    wr(CTRL_OFFSET, {16'h0000, c.ctrl});
    for (int k = 0; k < 5; k++) begin
      wait_cnt(sel, pts[k]);
      compare("pin", {31'h0, c.exp[4 - k]}, {31'h0, compare_output_pin_out});
    end
    compare("rises", rise_of(c.exp), {16'h0000, rises - r0});
    idle_mode_in <= 1'b0;
    $display("case %h done", c.ctrl);
  endtask : run_case

  initial begin
    reset_n_in = 1'b0;
    write_in = 1'b0;
    read_in = 1'b0;
    addr_in = 8'h00;
    wdata_in = 32'h0000_0000;
    idle_mode_in = 1'b0;
    fault_req = 1'b0;
    run = 2'b00;
    seed = 32'h0000_8CA0;
    repeat (6) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    rd(CTRL_OFFSET, 32'h0000_0000);
    wr(CTRL_OFFSET, 32'hFFFF_FFFF);
    rd(CTRL_OFFSET, 32'h0000_A02F);
    wr(CTRL_OFFSET + 8'h04, 32'h0000_8000);
    rd(CTRL_OFFSET, 32'h0000_202F);
    wr(CTRL_OFFSET + 8'h08, 32'h0000_8000);
    rd(CTRL_OFFSET, 32'h0000_A02F);
    wr(CTRL_OFFSET + 8'h0C, 32'h0000_0007);
    rd(CTRL_OFFSET, 32'h0000_A028);
    rd(CTRL_OFFSET + 8'h04, 32'h0000_0000);
    wr(8'h30, 32'hFFFF_FFFF);
    rd(8'h30, 32'h0000_0000);
    // compare registers keep random words, invert alias flips bits
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(PRIMARY_OFFSET, seed);
      rd(PRIMARY_OFFSET, seed);
      wr(SECONDARY_OFFSET, ~seed);
      wr(SECONDARY_OFFSET + 8'h0C, 32'h0F0F_F0F0);
      rd(SECONDARY_OFFSET, ~seed ^ 32'h0F0F_F0F0);
    end
    $display("register test done");
    foreach (CASES[i]) begin
      run_case(CASES[i]);
    end
    // fault is sticky, read-only and seen only in mode 111
    run <= 2'b01;
    wr(CTRL_OFFSET, 32'h0000_8007);
    fault_req <= 1'b1;
    repeat (6) @(posedge clk_in);
    rd(CTRL_OFFSET, 32'h0000_8017);
    wait_cnt(1'b0, 16'h0005);
    compare("pin", 32'h0000_0000, {31'h0, compare_output_pin_out});
    fault_req <= 1'b0;
    wr(CTRL_OFFSET + 8'h04, 32'h0000_0010);
    rd(CTRL_OFFSET, 32'h0000_8017);
    // read right after the mode change, while the old fault flag still stands
    addr_in <= CTRL_OFFSET;
    wdata_in <= 32'h0000_8006;
    write_in <= 1'b1;
    @(posedge clk_in);
    write_in <= 1'b0;
    exp_q.push_back(32'h0000_8006);
    read_in <= 1'b1;
    @(posedge clk_in);
    read_in <= 1'b0;
    fault_req <= 1'b1;
    @(posedge clk_in);
    wait_cnt(1'b0, 16'h0000);
    wait_cnt(1'b0, 16'h0005);
    compare("pin", 32'h0000_0001, {31'h0, compare_output_pin_out});
    fault_req <= 1'b0;
    wr(CTRL_OFFSET, 32'h0000_0000);
    $display("fault test done");
    wrap_up();
  end
endmodule : testbench

`default_nettype wire
